// *** verilog/hall_enc_defs.svh ***
// hall encoder output: offsets, fields, reset values and timing
`ifndef HALL_ENC_DEFS_SVH
`define HALL_ENC_DEFS_SVH

`define HE_POS_W        8
`define HE_ADDR_W       8
`define HE_CTRL_OFS     8'h00
`define HE_STAT_OFS     8'h04
`define HE_CTRL_EN_BIT  0
`define HE_CTRL_RST     1'h1
`define HE_RESP_OK      2'h0
`define HE_RESP_SLVERR  2'h2
`define HE_FAULT_SET    7'h32
`define HE_FAULT_CLR    7'h46
`define HE_HALF_TURN    8'h80
`define HE_CLK_NS       50
`define HE_EDGE_NS      4000
`define HE_EDGE_CYC     ((`HE_EDGE_NS + `HE_CLK_NS - 1) / `HE_CLK_NS)
`define HE_SYNC_NEN     7
`define HE_SYNC_CLK     6
`define HE_SYNC_RST     8'h80

`endif

// *** verilog/hall_enc_pkg.sv ***
// hall encoder output: shared types
`include "hall_enc_defs.svh"
package hall_enc_pkg;

  typedef enum logic [1:0] {LVL_LOW, LVL_OPEN, LVL_HIGH} level_e;
  typedef enum logic [2:0] {
    MODE_NONE, MODE_ABZ, MODE_CH_AB, MODE_CH_D, MODE_CH_S
  } mode_e;
  typedef enum logic [1:0] {PH_STANDBY, PH_SEARCH, PH_RUN} phase_e;
  typedef enum logic [1:0] {ANA_OFF, ANA_POS, ANA_NEG, ANA_REFGAIN} ana_e;

  typedef struct packed {
    logic                  awvalid;
    logic [`HE_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [`HE_ADDR_W-1:0] araddr;
    logic                  rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic [`HE_POS_W-1:0] pos;
  } stepper_s;

  typedef struct packed {
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic        clkPrev;
    mode_e       mode;
    logic [5:0]  cfg;
    phase_e      phase;
    logic        faultN;
    logic [7:0]  divCnt;
    logic        prmHalf;
    logic        stepTick;
    logic        pwr;
    logic        chActive;
    logic        chDone;
    logic        chPulse;
    logic        chLow;
    logic        chEnOut;
    logic        pinA;
    logic        pinAOe;
    logic        pinB;
    logic        pinBOe;
    logic        pinC;
    logic        pinCOe;
    logic        pinD;
    logic        pinDOe;
    ana_e        ana;
    logic        ctrlEn;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } hall_state_s;

endpackage

// *** verilog/quad_stepper.sv ***
// position follower: one resolution step per tick toward the angle
`timescale 1ns/10ps
`include "hall_enc_defs.svh"
module quad_stepper (
  input  logic                  core_clk,
  input  logic                  resetn,
  input  logic                  clear,
  input  logic                  stepEn,
  input  logic [`HE_POS_W-1:0]  target,
  input  logic [1:0]            shift,
  output logic [`HE_POS_W-1:0]  posQ,
  output logic                  atTarget
);

  hall_enc_pkg::stepper_s s, n;
  logic [`HE_POS_W-1:0] unit;
  logic [`HE_POS_W-1:0] tgt;
  logic [`HE_POS_W-1:0] diff;

  assign unit = `HE_POS_W'(1) << shift;
  assign tgt  = target & ~(unit - `HE_POS_W'(1));
  assign diff = tgt - s.pos;
  assign posQ = s.pos;
  assign atTarget = (diff == '0);

  always_comb begin
    n = s;
    if (clear) begin
      n.pos = '0;
    end else if (stepEn && !atTarget) begin
      // shortest way round; from zero this is up below half a turn
      if (diff[`HE_POS_W-1]) begin
        n.pos = s.pos - unit;
      end else begin
        n.pos = s.pos + unit;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_STEP_ONE: assert property (
    !clear |=> (posQ == $past(posQ)) ||
               (posQ == $past(posQ) + $past(unit)) ||
               (posQ == $past(posQ) - $past(unit)))
    else $error("position moved by more than one step");

  AST_CATCH_UP_DIR: assert property (
    (!clear && stepEn && !atTarget && posQ == '0 &&
     tgt < `HE_HALF_TURN) |=> posQ == $past(unit))
    else $error("catch-up from zero went the wrong way");

endmodule // quad_stepper

// *** verilog/hall_enc_output.sv ***
// hall encoder output logic: incremental abz and chain modes
// Operation
// - index high only at zero angle
// - fault low below 50%, released above 70%
// - resolutions of 6, 7, 8 bits
// - every edge emitted, no count skipped
// - reduced power halves the edge rate
// - index level option sets AB at index
// - abz config pin decode
// - search phase: A, B high, index low
// - catch up at maximum rate, then track
// - B leads A when counting up
// - chain enable sampled on clock rise
// - delayed enable activates next device
// - bus lines released outside active slot
// - chain config pin decode
// - chain quadrature, phase sign gives direction
// - quadrature chain hands over after one pulse
// - quadrature chain: low first, from zero
// - error holds quadrature chain lines low
// - differential chain: plain then inverted pair
// - single-ended chain: sine/cosine, then reference/gain
// - delayed enable high during standby
// - catch up from zero, direction by half
`timescale 1ns/10ps
`include "hall_enc_defs.svh"
module hall_enc_output (
  input  logic                    core_clk,
  input  logic                    resetn,
  input  hall_enc_pkg::axil_req_s axiReq,
  output hall_enc_pkg::axil_rsp_s axiRsp,
  input  logic                    chainEnableInN,
  input  logic [1:0]              configSel1,
  input  logic [1:0]              configSel2,
  input  logic [1:0]              configSel3,
  input  logic                    pinBIn,
  input  logic [7:0]              angle,
  input  logic [6:0]              amplitudePct,
  output logic                    pinAOut,
  output logic                    pinAOe,
  output logic                    pinBOut,
  output logic                    pinBOe,
  output logic                    pinCOut,
  output logic                    pinCOe,
  output logic                    pinDOut,
  output logic                    pinDOe,
  output hall_enc_pkg::ana_e      anaSel,
  output logic                    sensorPowerOn
);

  localparam logic [7:0] EDGE_CYC = 8'(`HE_EDGE_CYC);

  localparam hall_enc_pkg::hall_state_s ST_RST = '{
    sync1:    `HE_SYNC_RST,
    sync2:    `HE_SYNC_RST,
    mode:     hall_enc_pkg::MODE_NONE,
    phase:    hall_enc_pkg::PH_STANDBY,
    ana:      hall_enc_pkg::ANA_OFF,
    chEnOut:  1'b1,
    pinD:     1'b1,
    pwr:      1'b1,
    ctrlEn:   `HE_CTRL_RST,
    default:  '0
  };

  hall_enc_pkg::hall_state_s s, n;

  logic                nenS;
  logic                clkRise;
  logic                clkFall;
  logic                enabled;
  logic                isChain;
  logic                reduced_power_option;
  logic                idxHigh;
  logic                wrap;
  logic                chLast;
  logic [1:0]          shiftQ;
  logic [7:0]          abzPos;
  logic [7:0]          chPos;
  logic [1:0]          abzAB;
  logic [1:0]          chAB;
  logic                wrGo;
  logic                rdGo;
  logic [31:0]         statusWord;
  hall_enc_pkg::mode_e decMode;

  // three-level pins arrive as low/open/high codes
  function automatic hall_enc_pkg::mode_e decode_cfg(
    input logic [5:0] c
  );
    logic [1:0] c1;
    logic [1:0] c2;
    logic [1:0] c3;
    c1 = c[1:0];
    c2 = c[3:2];
    c3 = c[5:4];
    decode_cfg = hall_enc_pkg::MODE_NONE;
    if (c3 == hall_enc_pkg::LVL_LOW && c2 == hall_enc_pkg::LVL_HIGH) begin
      case (c1)
        hall_enc_pkg::LVL_LOW:  decode_cfg = hall_enc_pkg::MODE_CH_AB;
        hall_enc_pkg::LVL_OPEN: decode_cfg = hall_enc_pkg::MODE_CH_D;
        hall_enc_pkg::LVL_HIGH: decode_cfg = hall_enc_pkg::MODE_CH_S;
        default:                decode_cfg = hall_enc_pkg::MODE_NONE;
      endcase
    end else if ((c3 == hall_enc_pkg::LVL_OPEN ||
                  c3 == hall_enc_pkg::LVL_HIGH) &&
                 (c1 == hall_enc_pkg::LVL_LOW ||
                  c1 == hall_enc_pkg::LVL_OPEN) &&
                 c2 != 2'h3) begin
      decode_cfg = hall_enc_pkg::MODE_ABZ;
    end
  endfunction

  // {A,B} for a quadrature state; up-count makes B rise before A
  function automatic logic [1:0] quad_ab(
    input logic [1:0] st,
    input logic       hiAtIdx
  );
    logic [1:0] p;
    p = hiAtIdx ? st : st + 2'h2;
    quad_ab = {p < 2'h2, p == 2'h0 || p == 2'h3};
  endfunction

  assign nenS    = s.sync2[`HE_SYNC_NEN];
  assign clkRise = s.sync2[`HE_SYNC_CLK] & ~s.clkPrev;
  assign clkFall = ~s.sync2[`HE_SYNC_CLK] & s.clkPrev;
  assign enabled = ~nenS & s.ctrlEn;
  assign isChain = s.mode == hall_enc_pkg::MODE_CH_AB ||
                   s.mode == hall_enc_pkg::MODE_CH_D ||
                   s.mode == hall_enc_pkg::MODE_CH_S;
  assign reduced_power_option     = s.cfg[5:4] == hall_enc_pkg::LVL_HIGH;
  assign idxHigh = s.cfg[1:0] == hall_enc_pkg::LVL_LOW;
  // config_sel_2 low/open/high gives 8/7/6 bits
  assign shiftQ  = s.cfg[3:2] == hall_enc_pkg::LVL_HIGH ? 2'h2 :
                   s.cfg[3:2] == hall_enc_pkg::LVL_OPEN ? 2'h1 :
                   2'h0;
  assign wrap    = s.divCnt == EDGE_CYC - 8'h01;
  assign chLast  = isChain && (s.mode == hall_enc_pkg::MODE_CH_AB ||
                               s.chPulse);
  assign decMode = decode_cfg(s.sync2[5:0]);
  assign abzAB   = quad_ab(2'(abzPos >> shiftQ), idxHigh);
  assign chAB    = quad_ab(chPos[1:0], 1'b0);
  assign wrGo    = axiReq.awvalid & axiReq.wvalid & ~s.bvalid;
  assign rdGo    = axiReq.arvalid & ~s.rvalid;

  assign statusWord = {16'h0000, s.chDone, s.chActive, 3'(s.mode),
                       2'(s.phase), s.faultN, abzPos};

  quad_stepper uAbzStep (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clear    (s.phase != hall_enc_pkg::PH_RUN),
    .stepEn   (s.stepTick),
    .target   (angle),
    .shift    (shiftQ),
    .posQ     (abzPos),
    .atTarget ()
  );

  // chain position restarts from zero on every active slot
  quad_stepper uChainStep (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clear    (~s.chActive | s.chLow),
    .stepEn   (s.stepTick),
    .target   (angle),
    .shift    (2'h0),
    .posQ     (chPos),
    .atTarget ()
  );

  always_comb begin
    n = s;
    n.sync1 = {chainEnableInN, pinBIn, configSel3, configSel2,
               configSel1};
    n.sync2 = s.sync1;
    n.clkPrev = s.sync2[`HE_SYNC_CLK];

    // mode only follows the pins while the device is disabled
    if (nenS) begin
      n.mode = decMode;
      n.cfg  = s.sync2[5:0];
    end

    if (amplitudePct < `HE_FAULT_SET) begin
      n.faultN = 1'b0;
    end else if (amplitudePct > `HE_FAULT_CLR) begin
      n.faultN = 1'b1;
    end

    // edge pacing; reduced power keeps every second tick only
    n.divCnt = wrap ? 8'h00 : s.divCnt + 8'h01;
    if (wrap) begin
      n.prmHalf = ~s.prmHalf;
    end
    n.stepTick = wrap & (~reduced_power_option | s.prmHalf);
    n.pwr = ~reduced_power_option | s.prmHalf;

    if (!enabled || s.mode != hall_enc_pkg::MODE_ABZ) begin
      n.phase = hall_enc_pkg::PH_STANDBY;
    end else begin
      case (s.phase)
        hall_enc_pkg::PH_STANDBY: n.phase = hall_enc_pkg::PH_SEARCH;
        hall_enc_pkg::PH_SEARCH: begin
          if (s.faultN) begin
            n.phase = hall_enc_pkg::PH_RUN;
          end
        end
        hall_enc_pkg::PH_RUN:     n.phase = hall_enc_pkg::PH_RUN;
        default:                  n.phase = hall_enc_pkg::PH_STANDBY;
      endcase
    end

    if (!isChain) begin
      n.chActive = 1'b0;
      n.chDone   = 1'b0;
      n.chEnOut  = 1'b1;
    end else if (clkRise) begin
      if (nenS) begin
        // the controller's high enable clears the whole cascade
        n.chActive = 1'b0;
        n.chDone   = 1'b0;
        n.chEnOut  = 1'b1;
      end else if (!s.chActive && !s.chDone) begin
        n.chActive = 1'b1;
        n.chPulse  = 1'b0;
        n.chLow    = 1'b1;
      end else if (s.chActive) begin
        n.chPulse = 1'b1;
      end
    end else if (clkFall && s.chActive && chLast) begin
      n.chActive = 1'b0;
      n.chDone   = 1'b1;
      n.chEnOut  = 1'b0;
    end
    if (s.chActive && s.stepTick) begin
      n.chLow = 1'b0;
    end

    n.pinA   = 1'b0;
    n.pinB   = 1'b0;
    n.pinC   = 1'b0;
    n.pinD   = 1'b1;
    n.pinAOe = 1'b0;
    n.pinBOe = 1'b0;
    n.pinCOe = 1'b0;
    n.pinDOe = 1'b0;
    n.ana    = hall_enc_pkg::ANA_OFF;
    case (s.mode)
      hall_enc_pkg::MODE_ABZ: begin
        if (s.phase != hall_enc_pkg::PH_STANDBY) begin
          n.pinAOe = 1'b1;
          n.pinBOe = 1'b1;
          n.pinCOe = 1'b1;
          n.pinDOe = 1'b1;
          n.pinD   = s.faultN;
          if (s.phase == hall_enc_pkg::PH_SEARCH) begin
            n.pinA = 1'b1;
            n.pinB = 1'b1;
          end else begin
            {n.pinA, n.pinB} = abzAB;
            n.pinC = abzPos == 8'h00;
          end
        end
      end
      hall_enc_pkg::MODE_CH_AB: begin
        n.pinDOe = 1'b1;
        n.pinD   = s.chEnOut;
        n.pinAOe = s.chActive;
        n.pinCOe = s.chActive;
        if (s.chActive && !s.chLow && s.faultN) begin
          {n.pinA, n.pinC} = chAB;
        end
      end
      hall_enc_pkg::MODE_CH_D,
      hall_enc_pkg::MODE_CH_S: begin
        n.pinDOe = 1'b1;
        n.pinD   = s.chEnOut;
        n.pinAOe = s.chActive;
        n.pinCOe = s.chActive;
        if (s.chActive && !s.chPulse) begin
          n.ana = hall_enc_pkg::ANA_POS;
        end else if (s.chActive) begin
          n.ana = s.mode == hall_enc_pkg::MODE_CH_D ?
                  hall_enc_pkg::ANA_NEG :
                  hall_enc_pkg::ANA_REFGAIN;
        end
      end
      default: n.pinD = 1'b1;
    endcase

    if (s.bvalid && axiReq.bready) begin
      n.bvalid = 1'b0;
    end
    if (wrGo) begin
      n.bvalid = 1'b1;
      n.bresp  = `HE_RESP_OK;
      if (axiReq.awaddr == `HE_CTRL_OFS) begin
        if (axiReq.wstrb[0]) begin
          n.ctrlEn = axiReq.wdata[`HE_CTRL_EN_BIT];
        end
      end else if (axiReq.awaddr != `HE_STAT_OFS) begin
        n.bresp = `HE_RESP_SLVERR;
      end
    end
    if (s.rvalid && axiReq.rready) begin
      n.rvalid = 1'b0;
    end
    if (rdGo) begin
      n.rvalid = 1'b1;
      n.rresp  = `HE_RESP_OK;
      n.rdata  = 32'h0000_0000;
      if (axiReq.araddr == `HE_CTRL_OFS) begin
        n.rdata = {31'h0000_0000, s.ctrlEn};
      end else if (axiReq.araddr == `HE_STAT_OFS) begin
        n.rdata = statusWord;
      end else begin
        n.rresp = `HE_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  assign axiRsp.awready = wrGo;
  assign axiRsp.wready  = wrGo;
  assign axiRsp.bvalid  = s.bvalid;
  assign axiRsp.bresp   = s.bresp;
  assign axiRsp.arready = rdGo;
  assign axiRsp.rvalid  = s.rvalid;
  assign axiRsp.rdata   = s.rdata;
  assign axiRsp.rresp   = s.rresp;
  assign pinAOut = s.pinA;
  assign pinAOe  = s.pinAOe;
  assign pinBOut = s.pinB;
  assign pinBOe  = s.pinBOe;
  assign pinCOut = s.pinC;
  assign pinCOe  = s.pinCOe;
  assign pinDOut = s.pinD;
  assign pinDOe  = s.pinDOe;
  assign anaSel  = s.ana;
  assign sensorPowerOn = s.pwr;

  // helper: cycles since the last step tick
  logic [8:0] gapQ;
  logic       gapSeen;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gapQ    <= 9'h000;
      gapSeen <= 1'b0;
    end else begin
      gapQ    <= s.stepTick ? 9'h000 : gapQ + 9'h001;
      gapSeen <= enabled & (gapSeen | s.stepTick);
    end
  end

  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_INDEX_ZERO: assert property (
    (s.mode == hall_enc_pkg::MODE_ABZ &&
     s.phase == hall_enc_pkg::PH_RUN) |=>
      pinCOut == (($past(abzPos)) == 8'h00))
    else $error("index not tied to zero angle");

  AST_FAULT_SET: assert property (
    amplitudePct < `HE_FAULT_SET |=> !s.faultN)
    else $error("fault not raised below half amplitude");

  AST_FAULT_HOLD: assert property (
    (!s.faultN && amplitudePct <= `HE_FAULT_CLR) |=> !s.faultN)
    else $error("fault released too early");

  AST_SEARCH_OUT: assert property (
    (s.mode == hall_enc_pkg::MODE_ABZ &&
     s.phase == hall_enc_pkg::PH_SEARCH) |=>
      pinAOut && pinBOut && !pinCOut && pinAOe)
    else $error("search phase error pattern missing");

  AST_INDEX_LEVEL: assert property (
    (pinCOut && s.mode == hall_enc_pkg::MODE_ABZ) |->
      pinAOut == idxHigh && pinBOut == idxHigh)
    else $error("AB level at index wrong");

  AST_PRM_RATE: assert property (
    (s.stepTick && reduced_power_option && gapSeen) |->
      gapQ == 9'(2 * `HE_EDGE_CYC - 1))
    else $error("reduced power edge spacing wrong");

  AST_HANDOVER: assert property (
    (clkFall && s.chActive && chLast) |=> ##1
      !pinDOut && !pinAOe && !pinCOe)
    else $error("chain handover missing");

  AST_CHAIN_LOW: assert property (
    (s.mode == hall_enc_pkg::MODE_CH_AB && s.chActive &&
     (s.chLow || !s.faultN)) |=> !pinAOut && !pinCOut)
    else $error("chain bus lines not low");

  AST_D_INVERT: assert property (
    (s.mode == hall_enc_pkg::MODE_CH_D && s.chActive &&
     s.chPulse) |=> anaSel == hall_enc_pkg::ANA_NEG)
    else $error("inverted pair missing on second pulse");

  AST_AXI_BRESP: assert property (
    wrGo |=> axiRsp.bvalid [*1] ##0
      (axiRsp.bresp == `HE_RESP_OK) ==
      ($past(axiReq.awaddr) == `HE_CTRL_OFS ||
       $past(axiReq.awaddr) == `HE_STAT_OFS))
    else $error("write response wrong");

endmodule // hall_enc_output

// *** verification/position_host_model.sv ***
// far side: quadrature counter plus chain clock and enable source
`timescale 1ns/10ps
module position_host_model (
  input  wire logic               core_clk,
  input  wire logic               lineA,
  input  wire logic               lineB,
  output logic                    chainClk,
  output logic                    enableN,
  output logic signed [15:0]      count
);
  logic [1:0] prevQ;

  initial begin
    chainClk = 1'b0;
    enableN = 1'b1;
    count = 16'sh0000;
    prevQ = 2'h3;
  end

  // gray steps only; a double-bit jump moves nothing, so skips show up
  always @(posedge core_clk) begin
    prevQ <= {lineA, lineB};
    case ({prevQ, lineA, lineB})
      4'h1, 4'h7, 4'hE, 4'h8: count <= count + 16'sh0001;
      4'h2, 4'hB, 4'hD, 4'h4: count <= count - 16'sh0001;
      default: ;
    endcase
  end

  // raising the first enable stops every device in the cascade
  task automatic set_en(logic v);
    @(posedge core_clk);
    enableN <= v;
  endtask

  // clock stays low between frames
  task automatic set_clk(logic v);
    @(posedge core_clk);
    chainClk <= v;
  endtask
endmodule // position_host_model

// *** verification/hall_enc_output_tb.sv ***
// self-checking bench for the hall encoder output logic
`timescale 1ns/10ps
`include "hall_enc_defs.svh"
module hall_enc_output_tb;
  logic                    core_clk;
  logic                    resetn;
  hall_enc_pkg::axil_req_s axiReq;
  hall_enc_pkg::axil_rsp_s axiRsp;
  logic                    chainEnableInN;
  logic [1:0]              configSel1;
  logic [1:0]              configSel2;
  logic [1:0]              configSel3;
  logic                    pinBIn;
  logic [7:0]              angle;
  logic [6:0]              amplitudePct;
  logic                    pinAOut;
  logic                    pinAOe;
  logic                    pinBOut;
  logic                    pinBOe;
  logic                    pinCOut;
  logic                    pinCOe;
  logic                    pinDOut;
  logic                    pinDOe;
  hall_enc_pkg::ana_e      anaSel;
  logic                    sensorPowerOn;
  logic                    chainClk;
  logic signed [15:0]      count;
  logic signed [15:0]      base;
  logic [31:0]             rdData;
  logic [1:0]              rsp;
  int                      err_count = 0;
  int                      checked = 0;
  int                      pwrLow = 0;

  // pin b wire: device drives it in abz search and run, chain clock source otherwise
  assign pinBIn = pinBOe ? pinBOut : chainClk;

  hall_enc_output dut_u (.core_clk(core_clk), .resetn(resetn),
    .axiReq(axiReq), .axiRsp(axiRsp), .chainEnableInN(chainEnableInN),
    .configSel1(configSel1), .configSel2(configSel2),
    .configSel3(configSel3), .pinBIn(pinBIn), .angle(angle),
    .amplitudePct(amplitudePct), .pinAOut(pinAOut), .pinAOe(pinAOe),
    .pinBOut(pinBOut), .pinBOe(pinBOe), .pinCOut(pinCOut),
    .pinCOe(pinCOe), .pinDOut(pinDOut), .pinDOe(pinDOe),
    .anaSel(anaSel), .sensorPowerOn(sensorPowerOn));

  position_host_model host (.core_clk(core_clk), .lineA(pinAOut),
    .lineB(pinBOut), .chainClk(chainClk), .enableN(chainEnableInN),
    .count(count));

  always #25 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (sensorPowerOn === 1'b0) pwrLow <= pwrLow + 1;
  end

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask

  // sample before the edge, so the handshake edge is the taking edge
  task automatic hs(int which);
    logic r;
    for (int i = 0; i < 50; i++) begin
      @(negedge core_clk);
      case (which)
        0: r = axiRsp.awready && axiRsp.wready;
        1: r = axiRsp.bvalid;
        2: r = axiRsp.arready;
        default: r = axiRsp.rvalid;
      endcase
      rsp = (which == 1) ? axiRsp.bresp : axiRsp.rresp;
      rdData = axiRsp.rdata;
      @(posedge core_clk);
      if (r === 1'b1) return;
    end
    err_count++;
    $display("Error axi handshake expected 1 seen 0");
    give_verdict();
  endtask

  task automatic axi_write(logic [7:0] addr, logic [31:0] data,
                           logic [3:0] strb = 4'hF);
    @(posedge core_clk);
    axiReq.awaddr <= addr;
    axiReq.wdata <= data;
    axiReq.wstrb <= strb;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    hs(0);
    axiReq.awvalid <= 1'b0;
    axiReq.wvalid <= 1'b0;
    hs(1);
    axiReq.bready <= 1'b0;
  endtask

  task automatic axi_read(logic [7:0] addr);
    @(posedge core_clk);
    axiReq.araddr <= addr;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    hs(2);
    axiReq.arvalid <= 1'b0;
    hs(3);
    axiReq.rready <= 1'b0;
  endtask

  task automatic wait_count(logic signed [15:0] exp, output int spent);
    spent = 0;
    while (16'(count - base) !== exp) begin
      @(negedge core_clk);
      spent++;
      if (spent > 4000) begin
        err_count++;
        $display("Error count expected %0d seen %0d", exp, count - base);
        give_verdict();
      end
    end
  endtask

  task automatic reg_scenario();
    axi_read(`HE_CTRL_OFS);
    check("ctrl reset", 32'h1, rdData);
    axi_write(`HE_CTRL_OFS, 32'h0);
    host.set_en(1'b0);
    wait_cyc(10);
    axi_read(`HE_STAT_OFS);
    check("phase gated", 2'h0, rdData[10:9]);
    axi_write(`HE_CTRL_OFS, 32'h1);
    wait_cyc(6);
    axi_read(`HE_STAT_OFS);
    check("phase search", 2'h1, rdData[10:9]);
    axi_write(`HE_STAT_OFS, 32'hA5A5_5A5A);
    check("status write", `HE_RESP_OK, rsp);
    axi_write(8'hF8, 32'hFFFF_FFFF);
    check("unmapped write", `HE_RESP_SLVERR, rsp);
    axi_read(8'h8C);
    check("unmapped read", {30'h0, `HE_RESP_SLVERR}, {rdData[29:0], rsp});
    // bit 0 sits in byte lane 0; without that strobe the enable must stay
    axi_write(`HE_CTRL_OFS, 32'hFFFF_FFFE, 4'hE);
    axi_read(`HE_CTRL_OFS);
    check("ctrl strobe", 32'h1, rdData);
    // mid-run reset while the search pattern is being driven
    @(posedge core_clk);
    resetn <= 1'b0;
    wait_cyc(4);
    check("reset pins", 2'h1, {pinAOe, pinDOut});
    @(posedge core_clk);
    resetn <= 1'b1;
    axi_read(`HE_STAT_OFS);
    check("status after reset", 5'h00, rdData[13:9]);
  endtask

  task automatic abz_scenario(logic [1:0] s1, logic [1:0] s2,
                              logic [1:0] s3, logic [7:0] ang, int steps);
    logic [7:0] mask;
    logic [6:0] amps [4];
    int spent;
    int p0;
    mask = (s2 == 2'h0) ? 8'hFF : (s2 == 2'h1) ? 8'hFE : 8'hFC;
    amps = '{7'h32, 7'h31, 7'h46, 7'h47};
    host.set_en(1'b1);
    @(posedge core_clk);
    configSel1 <= s1;
    configSel2 <= s2;
    configSel3 <= s3;
    angle <= ang;
    amplitudePct <= 7'h28;
    wait_cyc(10);
    host.set_en(1'b0);
    wait_cyc(10);
    check("search ab", 3'h7, {pinAOe, pinAOut, pinBOut});
    check("search z", 0, pinCOut);
    check("fault set", 0, pinDOut);
    axi_read(`HE_STAT_OFS);
    check("mode", 3'h1, rdData[13:11]);
    @(posedge core_clk);
    amplitudePct <= 7'h50;
    for (int i = 0; i < 8 && pinDOut !== 1'b1; i++) @(negedge core_clk);
    check("fault clear", 1, pinDOut);
    base = count;
    p0 = pwrLow;
    wait_count(16'(steps), spent);
    check("pace", s3 == 2'h2, spent >= (steps < 0 ? -steps : steps) * 120);
    check("power gating", s3 == 2'h2, pwrLow != p0);
    axi_read(`HE_STAT_OFS);
    check("position", ang & mask, rdData[7:0]);
    check("index off", 0, pinCOut);
    @(posedge core_clk);
    angle <= 8'h00;
    wait_count(16'sh0000, spent);
    wait_cyc(2);
    check("index on", 1, pinCOut);
    check("index ab", {2{s1 == 2'h0}}, {pinAOut, pinBOut});
    // 50 keeps, 49 sets, 70 keeps, 71 clears
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      amplitudePct <= amps[i];
      wait_cyc(4);
      check("fault level", i == 0 || i == 3, pinDOut);
    end
  endtask

  task automatic chain_run(logic [1:0] s1, logic [2:0] mode,
                           hall_enc_pkg::ana_e second);
    host.set_en(1'b1);
    @(posedge core_clk);
    configSel1 <= s1;
    configSel2 <= 2'h2;
    configSel3 <= 2'h0;
    amplitudePct <= 7'h50;
    angle <= 8'h10;
    wait_cyc(10);
    check("standby enable out", 2'h3, {pinDOe, pinDOut});
    check("standby release", 0, {pinAOe, pinBOe});
    host.set_en(1'b0);
    wait_cyc(12);
    check("no clock no slot", 0, pinAOe);
    axi_read(`HE_STAT_OFS);
    check("chain mode", mode, rdData[13:11]);
    host.set_clk(1'b1);
    for (int i = 0; i < 12 && pinAOe !== 1'b1; i++) @(negedge core_clk);
    check("slot drive", 2'h3, {pinAOe, pinCOe});
    if (mode == 3'h2) begin
      check("lines low first", 0, {pinAOut, pinCOut});
      // counting up from zero: the second line must rise before the first
      for (int i = 0; i < 300 && pinCOut !== 1'b1; i++) @(negedge core_clk);
      check("chain c leads a", 2'h1, {pinAOut, pinCOut});
    end else begin
      check("ana first", hall_enc_pkg::ANA_POS, anaSel);
    end
    wait_cyc(10);
    host.set_clk(1'b0);
    wait_cyc(12);
    if (mode != 3'h2) begin
      check("still active", 1, pinAOe);
      host.set_clk(1'b1);
      wait_cyc(12);
      check("ana second", second, anaSel);
      host.set_clk(1'b0);
      wait_cyc(12);
    end
    check("hand over", 3'h0, {pinAOe, pinCOe, pinDOut});
    host.set_clk(1'b1);
    wait_cyc(12);
    check("done ignores", 0, pinAOe);
    host.set_clk(1'b0);
    wait_cyc(10);
    host.set_en(1'b1);
    host.set_clk(1'b1);
    wait_cyc(12);
    check("chain stop", 1, pinDOut);
    host.set_clk(1'b0);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    $display("Error run length expected finish seen hang");
    give_verdict();
  end

  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    axiReq = '0;
    configSel1 = 2'h0;
    configSel2 = 2'h0;
    configSel3 = 2'h1;
    angle = 8'h00;
    amplitudePct = 7'h28;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    reg_scenario();
    abz_scenario(2'h0, 2'h0, 2'h1, 8'h10, 16);
    abz_scenario(2'h1, 2'h1, 2'h2, 8'hF2, -7);
    abz_scenario(2'h0, 2'h2, 2'h1, 8'h42, 16);
    chain_run(2'h0, 3'h2, hall_enc_pkg::ANA_OFF);
    chain_run(2'h1, 3'h3, hall_enc_pkg::ANA_NEG);
    chain_run(2'h2, 3'h4, hall_enc_pkg::ANA_REFGAIN);
    give_verdict();
  end
endmodule // hall_enc_output_tb
